// ===== hdl/clock_source_mux_bank.sv
// Bank of clock source multiplexers for eight clock domains, with register port.
// Assumes source clocks arrive as slow levels relative to i_ref_clk and are
// re-timed here; each domain clock leaves as a registered level.
//
// Behaviour
// [R1] Strap high at boot makes the fast clock pad the high-speed source.
// [R2] With strap active, domains choosing high-speed run from the external fast clock.
// [R3] Strap choice is latched once; only system reset clears it.
// [R4] Two-bit code 00 gives high-speed or divided clock, 01 gives 32 kHz.
// [R5] A reserved two-bit code stops that domain's clock until system reset.
// [R6] One-bit switch: 1 selects 32 kHz, 0 high-speed; bits 31:1 read zero.
// [R7] Selector at 0x004 uses two-bit coding and drives clock 10.
// [R8] Selectors at 0x024 and 0x038 drive fabric clocks 16 and 21.
// [R9] Switch at 0x130 selects the source of clock 2.
// [R10] Switch at 0x134 selects the source of engine clock 8 X4.
// [R11] Switch at 0x138 selects the source of peripheral clock 11.
// [R12] Switches at 0x13C and 0x140 select converter clock 19 and gating clock 23.
// [R13] Source changes are glitch-free, handing over on low phases of both clocks; a rewrite during the pick can let the picked clock start mid-high.
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none
`include "clk_mux_consts.svh"

module clock_source_mux_bank
  import clk_mux_pkg::*;
#(
  parameter int N_DOM = `NUM_DOMAINS,
  parameter int N_WIDE = `NUM_WIDE_SEL
) (
  // Clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // Register port
  input  wire logic [11:0]      i_addr,
  input  wire logic [31:0]      i_wdata,
  input  wire logic             i_wr,
  input  wire logic             i_rd,
  output logic      [31:0]      o_rdata,
  // Clock sources and straps
  input  wire logic             i_hs_clk,
  input  wire logic             i_slow_clk,
  input  wire logic             i_fast_clock_pad,
  input  wire logic             i_boot_strap_pad,
  // Domain clocks and status
  output logic      [N_DOM-1:0] o_domain_clk,
  output logic                  o_strap_active
);

  // ========================================================================
  // State
  typedef struct packed {
    logic [3:0][2:0]                sync;
    logic [3:0]                     lvl;
    logic [1:0]                     strap_cnt;
    logic                           strap_done;
    logic                           strap;
    logic [N_DOM-1:0][1:0]          sel;
    logic [N_DOM-1:0][1:0]          st;
    logic [N_DOM-1:0]               src;
    logic [N_DOM-1:0]               clk_out;
    logic [31:0]                    rdata;
  } state_s;

  state_s s_q;
  state_s s_d;

  // ========================================================================
  // Address decode
  // Index order: 0 clock 10, 1 fabric 16, 2 fabric 21 (two-bit codes), then
  // clock 2, engine 8 X4, clock 11, clock 19, clock 23 (one-bit switches).
  function automatic logic [3:0] dom_lookup(input logic [11:0] a);
    logic [3:0] r;
    r = 4'h0;
    case (a)
      `OFS_CLK_TEN_SOURCE_MUX:             r = 4'h8; // [R7]
      `OFS_FABRIC_CLK_SOURCE_MUX:          r = 4'h9; // [R8]
      `OFS_FABRIC_EXTRA_CLK_SOURCE_MUX:    r = 4'ha; // [R8]
      `OFS_CLK_TWO_SOURCE_SWITCH:          r = 4'hb; // [R9]
      `OFS_ENGINE_X4_CLK_SOURCE_SWITCH:    r = 4'hc; // [R10]
      `OFS_PERIPHERAL_CLK_SOURCE_SWITCH:   r = 4'hd; // [R11]
      `OFS_CONVERTER_CLK_SOURCE_SWITCH:    r = 4'he; // [R12]
      `OFS_POWER_GATING_CLK_SOURCE_SWITCH: r = 4'hf; // [R12]
      default:                             r = 4'h0;
    endcase
    return r;
  endfunction : dom_lookup

  function automatic logic is_wide(input int idx);
    return idx < N_WIDE;
  endfunction : is_wide

  // ========================================================================
  // Next state
  logic [3:0]       wr_hit;
  logic [3:0]       rd_hit;
  logic             hs_lvl;
  logic             want;
  logic             old_lvl;
  logic             new_lvl;
  logic [N_DOM-1:0] dead_v;
  logic [N_DOM-1:0] pick_v;

  always_comb begin
    s_d     = s_q;
    wr_hit  = dom_lookup(i_addr);
    rd_hit  = wr_hit;
    hs_lvl  = 1'b0;
    want    = 1'b0;
    old_lvl = 1'b0;
    new_lvl = 1'b0;
    dead_v  = '0;
    pick_v  = '0;

    // Three-stage pin sampling; a level moves once stages two and three agree.
    for (int k = 0; k < 4; k++) begin
      s_d.sync[k] = {s_q.sync[k][1:0], 1'b0};
      if (s_q.sync[k][1] == s_q.sync[k][2]) begin
        s_d.lvl[k] = s_q.sync[k][2];
      end
    end
    s_d.sync[`SIG_HS][0]    = i_hs_clk;
    s_d.sync[`SIG_PAD][0]   = i_fast_clock_pad;
    s_d.sync[`SIG_SLOW][0]  = i_slow_clk;
    s_d.sync[`SIG_STRAP][0] = i_boot_strap_pad;

    // The strap is taken once the sampling chain has refilled after reset,
    // and never again: later pad changes and writes cannot undo it.
    if (!s_q.strap_done) begin
      if (s_q.strap_cnt == `STRAP_WAIT) begin
        s_d.strap_done = 1'b1;
        s_d.strap      = s_d.lvl[`SIG_STRAP]; // [R1]
      end else begin
        s_d.strap_cnt = s_q.strap_cnt + 2'h1;
      end
    end

    // High-speed source is the fast pad while the strap is held.
    hs_lvl = s_q.strap ? s_q.lvl[`SIG_PAD] : s_q.lvl[`SIG_HS]; // [R1] [R2] [R3]

    // Register writes.
    if (i_wr && wr_hit[3]) begin
      if (is_wide(int'(wr_hit[2:0]))) begin
        s_d.sel[wr_hit[2:0]] = i_wdata[1:0]; // [R4]
      end else begin
        s_d.sel[wr_hit[2:0]] = {1'b0, i_wdata[0]}; // [R6]
      end
    end

    // Per-domain switch sequencers.
    for (int i = 0; i < N_DOM; i++) begin
      want    = s_q.sel[i][0]; // [R4] [R6]
      old_lvl = s_q.src[i] ? s_q.lvl[`SIG_SLOW] : hs_lvl;
      new_lvl = want ? s_q.lvl[`SIG_SLOW] : hs_lvl;
      case (s_q.st[i])
        SW_RUN: begin
          s_d.clk_out[i] = old_lvl;
          // Hand over only in the old clock's low phase so no high is cut short.
          if (want != s_q.src[i] && !old_lvl) begin // [R13]
            s_d.st[i]      = SW_PICK;
            s_d.src[i]     = want;
            s_d.clk_out[i] = 1'b0;
          end
        end
        SW_PICK: begin
          s_d.clk_out[i] = 1'b0;
          // Release on the new clock's low phase so its first high is whole.
          if (!new_lvl) begin // [R13]
            s_d.st[i] = SW_RUN;
          end
        end
        SW_DEAD: begin
          s_d.clk_out[i] = 1'b0; // [R5]
        end
        default: begin
          s_d.st[i]      = SW_DEAD;
          s_d.clk_out[i] = 1'b0;
        end
      endcase
      // A reserved code kills the domain; nothing but reset leaves this state.
      if (is_wide(i) && s_q.sel[i][1]) begin // [R5]
        s_d.st[i]      = SW_DEAD;
        s_d.clk_out[i] = 1'b0;
      end
      dead_v[i] = (s_q.st[i] == SW_DEAD);
      pick_v[i] = (s_q.st[i] == SW_PICK);
    end

    // Register reads; data stand for the one cycle after the strobe.
    s_d.rdata = 32'h0;
    if (i_rd) begin
      if (rd_hit[3]) begin
        s_d.rdata[1:0] = s_q.sel[rd_hit[2:0]]; // [R6]
      end else if (i_addr == `OFS_MUX_BANK_STATUS) begin
        s_d.rdata[`STAT_DEAD_LSB +: N_DOM] = dead_v;
        s_d.rdata[`STAT_PICK_LSB +: N_DOM] = pick_v;
        s_d.rdata[`STAT_STRAP_BIT]         = s_q.strap;
      end
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_q      <= '0;
      s_q.sel  <= {N_DOM{`SEL_RESET}};
      s_q.st   <= {N_DOM{SW_RUN}};
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rdata        = s_q.rdata;
  assign o_domain_clk   = s_q.clk_out;
  assign o_strap_active = s_q.strap;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);

  property p_strap_sticky;
    s_q.strap_done |=> s_q.strap_done && $stable(s_q.strap);
  endproperty
  a_strap_sticky: assert property (p_strap_sticky) // [R3]
    else $error("strap selection changed after it was taken");

  property p_strap_taken;
    $rose(s_q.strap_done) |-> s_q.strap == s_q.lvl[`SIG_STRAP];
  endproperty
  a_strap_taken: assert property (p_strap_taken) // [R1]
    else $error("strap not taken from sampled pad level");

  property p_fast_pad_feeds;
    s_q.strap && s_q.st[0] == SW_RUN && !s_q.src[0] && s_q.sel[0] == `SEL_CODE_FAST
      |=> o_domain_clk[0] == $past(s_q.lvl[`SIG_PAD]);
  endproperty
  a_fast_pad_feeds: assert property (p_fast_pad_feeds) // [R2]
    else $error("high-speed domain not fed from fast pad under strap");

  property p_reserved_kills;
    i_wr && i_addr == `OFS_FABRIC_CLK_SOURCE_MUX && i_wdata[1]
      |=> ##1 s_q.st[1] == SW_DEAD ##1 !o_domain_clk[1];
  endproperty
  a_reserved_kills: assert property (p_reserved_kills) // [R5]
    else $error("reserved code did not stop the domain clock");

  property p_dead_stays;
    s_q.st[0] == SW_DEAD |=> s_q.st[0] == SW_DEAD && !o_domain_clk[0] [*4];
  endproperty
  a_dead_stays: assert property (p_dead_stays) // [R5]
    else $error("dead domain recovered without reset");

  property p_wide_slow_code;
    i_wr && i_addr == `OFS_CLK_TEN_SOURCE_MUX && i_wdata[1:0] == `SEL_CODE_SLOW
      |=> s_q.sel[0] == `SEL_CODE_SLOW;
  endproperty
  a_wide_slow_code: assert property (p_wide_slow_code) // [R7]
    else $error("clock 10 selector did not take the slow code");

  property p_narrow_read_zero;
    i_rd && i_addr == `OFS_CONVERTER_CLK_SOURCE_SWITCH |=> o_rdata[31:1] == 31'h0;
  endproperty
  a_narrow_read_zero: assert property (p_narrow_read_zero) // [R6]
    else $error("one-bit switch read shows upper bits");

  property p_slow_feeds;
    s_q.st[3] == SW_RUN && s_q.src[3] && s_q.sel[3][0]
      |=> o_domain_clk[3] == $past(s_q.lvl[`SIG_SLOW]);
  endproperty
  a_slow_feeds: assert property (p_slow_feeds) // [R9]
    else $error("clock 2 not fed from the slow clock");

  property p_switch_low;
    $changed(s_q.src[5]) |-> s_q.st[5] == SW_PICK && !o_domain_clk[5];
  endproperty
  a_switch_low: assert property (p_switch_low) // [R13]
    else $error("source change without a low phase");

  property p_no_runt;
    $fell(o_domain_clk[4]) && s_q.st[4] == SW_PICK |-> $past(s_q.st[4]) == SW_RUN;
  endproperty
  a_no_runt: assert property (p_no_runt) // [R13]
    else $error("engine clock cut while not running");

  // Per-domain routing checks: each watches one domain, so a slip in the
  // address decode or the domain order shows up on that domain alone.
  property p_extra_fast_code;
    i_wr && i_addr == `OFS_FABRIC_EXTRA_CLK_SOURCE_MUX && i_wdata[1:0] == `SEL_CODE_FAST
      |=> s_q.sel[2] == `SEL_CODE_FAST;
  endproperty
  a_extra_fast_code: assert property (p_extra_fast_code) // [R8]
    else $error("fabric clock 21 selector did not take the fast code");

  property p_fabric_slow_feeds;
    s_q.st[1] == SW_RUN && s_q.src[1] && s_q.sel[1] == `SEL_CODE_SLOW
      |=> o_domain_clk[1] == $past(s_q.lvl[`SIG_SLOW]);
  endproperty
  a_fabric_slow_feeds: assert property (p_fabric_slow_feeds) // [R4]
    else $error("fabric clock 16 not fed from the slow clock");

  property p_clk_ten_hs_feeds;
    !s_q.strap && s_q.st[0] == SW_RUN && !s_q.src[0] && s_q.sel[0] == `SEL_CODE_FAST
      |=> o_domain_clk[0] == $past(s_q.lvl[`SIG_HS]);
  endproperty
  a_clk_ten_hs_feeds: assert property (p_clk_ten_hs_feeds) // [R7]
    else $error("clock 10 not fed from the high-speed clock");

  property p_narrow_keeps_bit0;
    i_wr && i_addr == `OFS_PERIPHERAL_CLK_SOURCE_SWITCH
      |=> s_q.sel[5] == {1'b0, $past(i_wdata[0])};
  endproperty
  a_narrow_keeps_bit0: assert property (p_narrow_keeps_bit0) // [R11]
    else $error("clock 11 switch did not keep only bit 0");

  property p_converter_slow_feeds;
    s_q.st[6] == SW_RUN && s_q.src[6] && s_q.sel[6][0]
      |=> o_domain_clk[6] == $past(s_q.lvl[`SIG_SLOW]);
  endproperty
  a_converter_slow_feeds: assert property (p_converter_slow_feeds) // [R12]
    else $error("converter clock 19 not fed from the slow clock");

  property p_gating_hs_feeds;
    !s_q.strap && s_q.st[7] == SW_RUN && !s_q.src[7] && !s_q.sel[7][0]
      |=> o_domain_clk[7] == $past(s_q.lvl[`SIG_HS]);
  endproperty
  a_gating_hs_feeds: assert property (p_gating_hs_feeds) // [R12]
    else $error("gating clock 23 not fed from the high-speed clock");

  property p_engine_pad_feeds;
    s_q.strap && s_q.st[4] == SW_RUN && !s_q.src[4] && !s_q.sel[4][0]
      |=> o_domain_clk[4] == $past(s_q.lvl[`SIG_PAD]);
  endproperty
  a_engine_pad_feeds: assert property (p_engine_pad_feeds) // [R10]
    else $error("engine clock 8 X4 not fed from the fast pad under strap");

  property p_pick_quiet;
    s_q.st[6] == SW_PICK |-> !o_domain_clk[6];
  endproperty
  a_pick_quiet: assert property (p_pick_quiet) // [R13]
    else $error("converter clock 19 not held low while switching");

  property p_dead_status;
    i_rd && i_addr == `OFS_MUX_BANK_STATUS && s_q.st[2] == SW_DEAD
      |=> o_rdata[`STAT_DEAD_LSB + 2];
  endproperty
  a_dead_status: assert property (p_dead_status) // [R5]
    else $error("status does not show fabric clock 21 stopped");

  property p_wide_read_upper;
    i_rd && i_addr == `OFS_CLK_TEN_SOURCE_MUX |=> o_rdata[31:2] == 30'h0;
  endproperty
  a_wide_read_upper: assert property (p_wide_read_upper) // [R4]
    else $error("two-bit selector read shows upper bits");

endmodule : clock_source_mux_bank

`default_nettype wire

// ===== hdl/clk_mux_consts.svh
// Constants for the clock source multiplexer bank: offsets, fields, resets, counts.
// Assumes byte addresses on a 12-bit register port with 32-bit data.
`ifndef CLK_MUX_CONSTS_SVH
`define CLK_MUX_CONSTS_SVH

// ==========================================================================
// Register offsets
`define OFS_CLK_TEN_SOURCE_MUX          12'h004
`define OFS_FABRIC_CLK_SOURCE_MUX       12'h024
`define OFS_FABRIC_EXTRA_CLK_SOURCE_MUX 12'h038
`define OFS_CLK_TWO_SOURCE_SWITCH       12'h130
`define OFS_ENGINE_X4_CLK_SOURCE_SWITCH 12'h134
`define OFS_PERIPHERAL_CLK_SOURCE_SWITCH 12'h138
`define OFS_CONVERTER_CLK_SOURCE_SWITCH 12'h13c
`define OFS_POWER_GATING_CLK_SOURCE_SWITCH 12'h140
`define OFS_MUX_BANK_STATUS             12'h200

// ==========================================================================
// Field layout and codes
`define NUM_DOMAINS      8
`define NUM_WIDE_SEL     3
`define SEL_CODE_FAST    2'h0
`define SEL_CODE_SLOW    2'h1
`define SEL_RESET        2'h0
`define STAT_DEAD_LSB    0
`define STAT_PICK_LSB    8
`define STAT_STRAP_BIT   16

// ==========================================================================
// Sampled inputs and timing
`define SIG_HS           0
`define SIG_PAD          1
`define SIG_SLOW         2
`define SIG_STRAP        3
`define STRAP_WAIT       2'h3

`endif

// ===== hdl/clk_mux_pkg.sv
// Types shared by the clock source multiplexer bank.
// Assumes the constants header is compiled alongside.
package clk_mux_pkg;

  // ========================================================================
  // Per-domain switch sequencer states, Gray along run -> pick -> run.
  typedef enum logic [1:0] {
    SW_RUN  = 2'h0,
    SW_PICK = 2'h1,
    SW_DEAD = 2'h3
  } sw_state_e;

  typedef logic [1:0] sel_t;

endpackage : clk_mux_pkg

// ===== test/clock_source_mux_bank_test.sv
// Self-checking testbench for the clock source multiplexer bank.
// Assumes the design, its package and constants header are compiled first.
`timescale 1ns/10ps
`default_nettype none
`include "clk_mux_consts.svh"

module clock_source_mux_bank_test
  import clk_mux_pkg::*;
;
  logic        i_ref_clk = 1'b0;
  logic        i_rst = 1'b1;
  logic [11:0] i_addr = 12'h000;
  logic [31:0] i_wdata = 32'h0;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic [31:0] o_rdata;
  logic        i_hs_clk = 1'b0;
  logic        i_slow_clk = 1'b0;
  logic        i_fast_clock_pad = 1'b0;
  logic        i_boot_strap_pad = 1'b0;
  logic [7:0]  o_domain_clk;
  logic        o_strap_active;
  int          error_cnt = 0;
  int          samples_checked = 0;
  logic [11:0] regs [8] = '{`OFS_CLK_TEN_SOURCE_MUX, `OFS_FABRIC_CLK_SOURCE_MUX,
    `OFS_FABRIC_EXTRA_CLK_SOURCE_MUX, `OFS_CLK_TWO_SOURCE_SWITCH, `OFS_ENGINE_X4_CLK_SOURCE_SWITCH,
    `OFS_PERIPHERAL_CLK_SOURCE_SWITCH, `OFS_CONVERTER_CLK_SOURCE_SWITCH,
    `OFS_POWER_GATING_CLK_SOURCE_SWITCH};

  clock_source_mux_bank dut (
    .i_ref_clk       (i_ref_clk),
    .i_rst           (i_rst),
    .i_addr          (i_addr),
    .i_wdata         (i_wdata),
    .i_wr            (i_wr),
    .i_rd            (i_rd),
    .o_rdata         (o_rdata),
    .i_hs_clk        (i_hs_clk),
    .i_slow_clk      (i_slow_clk),
    .i_fast_clock_pad(i_fast_clock_pad),
    .i_boot_strap_pad(i_boot_strap_pad),
    .o_domain_clk    (o_domain_clk),
    .o_strap_active  (o_strap_active)
  );

  initial begin
    forever #5 i_ref_clk = ~i_ref_clk;
  end

  // ==========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data are valid only in the cycle after the strobe, so they are sampled there.
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    check("rdata", o_rdata, exp);
  endtask : rd

  // Source levels move slowly against the reference clock and need the re-timing flops.
  task automatic set_src(input logic h, input logic s, input logic p);
    @(posedge i_ref_clk);
    i_hs_clk <= h;
    i_slow_clk <= s;
    i_fast_clock_pad <= p;
    repeat (12) @(posedge i_ref_clk);
    #1;
  endtask : set_src

  task automatic do_reset(input logic strap);
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    i_boot_strap_pad <= strap;
    repeat (8) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (12) @(posedge i_ref_clk);
    #1;
  endtask : do_reset

  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  // ==========================================================================
  // Scenarios
  task automatic test_regs();
    for (int i = 0; i < 8; i++) rd(regs[i], 32'h0);
    rd(12'h100, 32'h0);
    wr(12'h100, 32'hffffffff);
    rd(12'h100, 32'h0);
    for (int i = 3; i < 8; i++) wr(regs[i], 32'hffffffff);
    for (int i = 3; i < 8; i++) rd(regs[i], 32'h1);
    for (int i = 0; i < 3; i++) wr(regs[i], 32'h1);
    for (int i = 0; i < 3; i++) rd(regs[i], 32'h1);
    $display("test regs done");
  endtask : test_regs

  task automatic test_select();
    set_src(1'b0, 1'b0, 1'b0);
    set_src(1'b0, 1'b1, 1'b0);
    check("all slow", {24'h0, o_domain_clk}, 32'hff);
    set_src(1'b1, 1'b0, 1'b0);
    check("slow not hs", {24'h0, o_domain_clk}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      set_src(1'b0, 1'b0, 1'b0);
      wr(regs[i], 32'h0);
      set_src(1'b1, 1'b0, 1'b0);
      check("domain map", {24'h0, o_domain_clk}, 32'h1 << i);
      set_src(1'b0, 1'b0, 1'b0);
      wr(regs[i], 32'h1);
    end
    $display("test select done");
  endtask : test_select

  task automatic test_reserved();
    set_src(1'b0, 1'b0, 1'b0);
    wr(regs[0], 32'h2);
    wr(regs[1], 32'h2);
    wr(regs[2], 32'h3);
    rd(regs[0], 32'h2);
    rd(regs[2], 32'h3);
    wr(regs[0], 32'h1);
    wr(regs[1], 32'h1);
    wr(regs[2], 32'h0);
    set_src(1'b1, 1'b1, 1'b0);
    check("dead domains", {24'h0, o_domain_clk}, 32'hf8);
    rd(`OFS_MUX_BANK_STATUS, 32'h7);
    set_src(1'b0, 1'b0, 1'b0);
    do_reset(1'b0);
    set_src(1'b1, 1'b0, 1'b0);
    check("revived", {24'h0, o_domain_clk}, 32'hff);
    $display("test reserved done");
  endtask : test_reserved

  task automatic test_strap();
    set_src(1'b0, 1'b0, 1'b1);
    do_reset(1'b1);
    check("strap", {31'h0, o_strap_active}, 32'h1);
    rd(`OFS_MUX_BANK_STATUS, 32'h10000);
    check("pad feeds", {24'h0, o_domain_clk}, 32'hff);
    set_src(1'b1, 1'b0, 1'b0);
    check("hs ignored", {24'h0, o_domain_clk}, 32'h0);
    // Dropping the strap pad now must not undo the choice taken at boot.
    @(posedge i_ref_clk);
    i_boot_strap_pad <= 1'b0;
    for (int i = 0; i < 8; i++) wr(regs[i], 32'h0);
    wr(`OFS_MUX_BANK_STATUS, 32'h0);
    set_src(1'b0, 1'b0, 1'b1);
    check("strap kept", {31'h0, o_strap_active}, 32'h1);
    check("pad kept", {24'h0, o_domain_clk}, 32'hff);
    set_src(1'b1, 1'b0, 1'b0);
    do_reset(1'b0);
    check("strap cleared", {31'h0, o_strap_active}, 32'h0);
    check("hs back", {24'h0, o_domain_clk}, 32'hff);
    $display("test strap done");
  endtask : test_strap

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    do_reset(1'b0);
    test_regs();
    test_select();
    test_reserved();
    test_strap();
    results();
  end

  // The tests need under a thousand cycles; the limit leaves ample margin.
  initial begin
    #200000;
    error_cnt++;
    results();
  end
endmodule : clock_source_mux_bank_test
`default_nettype wire
